// ---- inc/pbco_consts.svh ----
// Purpose: Constants for the port B/C alternate function override block.
// Assumes: 100 MHz system clock.
// Notes:   Times are in nanoseconds; cycle counts derive from them.
`ifndef PBCO_CONSTS_SVH
`define PBCO_CONSTS_SVH
`define PBCO_CLK_PERIOD_NS   10
`define PBCO_SPIKE_NS        50
// Spikes shorter than the limit are rejected, so the filter needs a whole number of cycles, rounded up.
`define PBCO_SPIKE_CYC       ((`PBCO_SPIKE_NS + `PBCO_CLK_PERIOD_NS - 1) / `PBCO_CLK_PERIOD_NS)
`define PBCO_PINB_SS         2
`define PBCO_PINB_MOSI       3
`define PBCO_PINB_OCA        1
`define PBCO_PINB_CAP        0
`define PBCO_PINC_RST        6
`define PBCO_PINC_CLK        5
`define PBCO_PINC_DAT        4
`define PBCO_RESET_BYTE      8'h00
`endif

// ---- inc/pbco_pkg.sv ----
// Purpose: Types for the port B/C alternate function override block.
// Assumes: Nothing beyond the constants header.
// Notes:   The filter state enum is shared with its leaf module.
package pbco_pkg;
  typedef enum logic [0:0] {
    PBCO_LOW  = 1'b0,
    PBCO_HIGH = 1'b1
  } pbco_level_t;
endpackage

// ---- rtl/pbco_spike_filter.sv ----
// Purpose: Rejects pulses shorter than a set number of cycles on one line.
// Assumes: Input already synchronised to clk.
// Notes:   Output changes only after the input held a new level for CYCLES edges.
`timescale 1ns/1ps
`default_nettype none
`include "pbco_consts.svh"
module pbco_spike_filter #(
  parameter int CYCLES = `PBCO_SPIKE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Line
  input  wire logic lineIn,
  output var  logic lineOut
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count;
  pbco_pkg::pbco_level_t level;
  wire differs = (lineIn != level);
  wire done    = (count == CW'(CYCLES - 1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      level <= pbco_pkg::PBCO_HIGH;
    end else if (!differs) begin
      count <= '0;
    end else if (done) begin
      count <= '0;
      level <= pbco_pkg::pbco_level_t'(lineIn);
    end else begin
      count <= count + CW'(1);
    end
  end
  assign lineOut = level;
endmodule
`default_nettype wire

// ---- rtl/pbco_override.sv ----
// Purpose: Override logic giving port B pins 0..3 and port C pins 4..6 to alternate functions.
// Assumes: Port bits and peripheral signals come from clk-domain logic; pads are asynchronous.
// Notes:   Pad inputs pass two flops; all outputs are registered, so they lag a port bit or peripheral change by one edge.
`timescale 1ns/1ps
`default_nettype none
`include "pbco_consts.svh"
module pbco_override (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Port B general-purpose bits, pins 0..3
  input  wire logic [3:0] dirBitPortb,
  input  wire logic [3:0] outBitPortb,
  // Port C general-purpose bits, pins 4..6 in positions 4..6
  input  wire logic [6:0] dirBitPortc,
  input  wire logic [6:0] outBitPortc,
  input  wire logic       globalPullupDisable,
  input  wire logic       resetPinDisableFuse,
  // Pads
  input  wire logic [3:0] padInPortb,
  input  wire logic [6:0] padInPortc,
  output logic      [3:0] padOutPortb,
  output logic      [3:0] padOePortb,
  output logic      [3:0] padPullupPortb,
  output logic      [6:0] padOutPortc,
  output logic      [6:0] padOePortc,
  output logic      [6:0] padPullupPortc,
  // Port readback
  output logic      [3:0] inBitPortb,
  output logic      [6:0] inBitPortc,
  output logic      [6:0] dirReadPortc,
  output logic      [6:0] outReadPortc,
  // SPI
  input  wire logic       spiEnableBit,
  input  wire logic       spiMasterSelect,
  input  wire logic       spiMasterOut,
  input  wire logic       spiSlaveOut,
  output logic            spiSlaveIn,
  output logic            spiMasterIn,
  output logic            spiSlaveSelectIn,
  output logic            spiSlaveActive,
  // MISO pad of the shared pin (pin B4)
  input  wire logic       padInMiso,
  output logic            padOutMiso,
  output logic            padOeMiso,
  input  wire logic       dirBitMiso,
  // Timers
  input  wire logic       timer2CompareOut,
  input  wire logic       timer2CompareEn,
  input  wire logic       timer1CompareAOut,
  input  wire logic       timer1CompareAEn,
  input  wire logic       timer1CompareBOut,
  input  wire logic       timer1CompareBEn,
  output logic            timer1CaptureIn,
  // Reset circuitry
  output logic            resetPinLevel,
  // Two-wire interface
  input  wire logic       twowireEnable,
  input  wire logic       twowireClkDriveLow,
  input  wire logic       twowireDatDriveLow,
  output logic            twowireClkIn,
  output logic            twowireDatIn
);
  // ====================================================================
  // Input synchronisers
  logic [3:0] syncB1, syncB2;
  logic [6:0] syncC1, syncC2;
  logic       syncM1, syncM2;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncB1 <= 4'h0;
      syncB2 <= 4'h0;
      syncC1 <= 7'h00;
      syncC2 <= 7'h00;
      syncM1 <= 1'b0;
      syncM2 <= 1'b0;
    end else begin
      syncB1 <= padInPortb;
      syncB2 <= syncB1;
      syncC1 <= padInPortc;
      syncC2 <= syncC1;
      syncM1 <= padInMiso;
      syncM2 <= syncM1;
    end
  end

  // ====================================================================
  // Two-wire spike filters
  // The filters run on the synchronised pad level, ahead of the two-wire logic.
  logic filtClk, filtDat;
  pbco_spike_filter #(.CYCLES(`PBCO_SPIKE_CYC)) u_filtClk (
    .clk     (clk),
    .arst_n  (arst_n),
    .lineIn  (syncC2[`PBCO_PINC_CLK]),
    .lineOut (filtClk)
  );
  pbco_spike_filter #(.CYCLES(`PBCO_SPIKE_CYC)) u_filtDat (
    .clk     (clk),
    .arst_n  (arst_n),
    .lineIn  (syncC2[`PBCO_PINC_DAT]),
    .lineOut (filtDat)
  );

  // ====================================================================
  // Override signals
  wire spiMaster = spiEnableBit & spiMasterSelect;
  wire spiSlave  = spiEnableBit & ~spiMasterSelect;
  // Pins B2/B3: a slave forces input; pull-up then from the output bit.
  wire [3:0] dirOvEn  = {spiSlave, spiSlave, 2'b00};
  wire [3:0] dirOvVal = 4'h0;
  wire [3:0] puOvEn   = {spiSlave, spiSlave, 2'b00};
  wire [3:0] puOvVal  = outBitPortb & {4{~globalPullupDisable}};
  // Value overrides only steer the level; the driver stays with the direction bit.
  wire b3ValEn  = spiMaster | timer2CompareEn;
  wire b3Val    = (spiMaster & spiMasterOut) | (timer2CompareEn & timer2CompareOut);
  wire [3:0] valOvEn  = {b3ValEn, timer1CompareBEn, timer1CompareAEn, 1'b0};
  wire [3:0] valOvVal = {b3Val, timer1CompareBOut, timer1CompareAOut, 1'b0};

  // Generic pad equations shared by all port B pins.
  wire [3:0] defPuB   = ~dirBitPortb & outBitPortb & {4{~globalPullupDisable}};
  wire [3:0] next_oeB = (dirOvEn & dirOvVal) | (~dirOvEn & dirBitPortb);
  wire [3:0] next_puB = (puOvEn & puOvVal) | (~puOvEn & defPuB);
  wire [3:0] next_outB = (valOvEn & valOvVal) | (~valOvEn & outBitPortb);

  // Port C: pin 6 reset, pins 5/4 two-wire open-drain.
  wire rstIo   = resetPinDisableFuse;
  wire [6:0] defPuC   = ~dirBitPortc & outBitPortc & {7{~globalPullupDisable}};
  wire [6:0] twMask   = {1'b0, twowireEnable, twowireEnable, 4'h0};
  wire [6:0] rstMask  = {~rstIo, 6'h00};
  wire [6:0] twOe     = {1'b0, twowireClkDriveLow, twowireDatDriveLow, 4'h0};
  wire [6:0] next_oeC = (twMask & twOe) | (~twMask & ~rstMask & dirBitPortc);
  wire [6:0] next_outC = ~twMask & ~rstMask & outBitPortc;
  // Unprogrammed fuse: the reset pin keeps its pull-up on.
  wire [6:0] next_puC = rstMask | (~twMask & ~rstMask & defPuC);
  wire [6:0] next_inC = ~twMask & ~rstMask & syncC2;

  // ====================================================================
  // Registered outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      padOutPortb      <= 4'h0;
      padOePortb       <= 4'h0;
      padPullupPortb   <= 4'h0;
      padOutPortc      <= 7'h00;
      padOePortc       <= 7'h00;
      padPullupPortc   <= 7'h00;
      inBitPortb       <= 4'h0;
      inBitPortc       <= 7'h00;
      dirReadPortc     <= 7'h00;
      outReadPortc     <= 7'h00;
      spiSlaveIn       <= 1'b0;
      spiMasterIn      <= 1'b0;
      spiSlaveSelectIn <= 1'b1;
      spiSlaveActive   <= 1'b0;
      padOutMiso       <= 1'b0;
      padOeMiso        <= 1'b0;
      timer1CaptureIn  <= 1'b0;
      resetPinLevel    <= 1'b1;
      twowireClkIn     <= 1'b1;
      twowireDatIn     <= 1'b1;
    end else begin
      padOutPortb      <= next_outB;
      padOePortb       <= next_oeB;
      padPullupPortb   <= next_puB;
      padOutPortc      <= next_outC;
      padOePortc       <= next_oeC;
      padPullupPortc   <= next_puC;
      inBitPortb       <= syncB2;
      inBitPortc       <= next_inC;
      dirReadPortc     <= ~rstMask & dirBitPortc;
      outReadPortc     <= ~rstMask & outBitPortc;
      spiSlaveIn       <= syncB2[`PBCO_PINB_MOSI];
      spiMasterIn      <= syncM2;
      spiSlaveSelectIn <= syncB2[`PBCO_PINB_SS];
      spiSlaveActive   <= spiSlave & ~syncB2[`PBCO_PINB_SS];
      padOutMiso       <= spiSlave ? spiSlaveOut : 1'b0;
      padOeMiso        <= ~spiMaster & dirBitMiso;
      timer1CaptureIn  <= syncB2[`PBCO_PINB_CAP];
      resetPinLevel    <= rstIo | syncC2[`PBCO_PINC_RST];
      twowireClkIn     <= filtClk;
      twowireDatIn     <= filtDat;
    end
  end

  // ====================================================================
  // Assertions
  sequence s_slaveOn;
    spiSlave;
  endsequence
  sequence s_b3Input;
    !padOePortb[3];
  endsequence
  a_slave_b3_input:   assert property (@(posedge clk) disable iff (!arst_n) s_slaveOn |=> s_b3Input) else $error("B3 driven in slave");
  a_slave_b2_input:   assert property (@(posedge clk) disable iff (!arst_n) spiSlave |=> !padOePortb[2]) else $error("B2 driven in slave");
  a_master_b3_dir:    assert property (@(posedge clk) disable iff (!arst_n) spiMaster |=> padOePortb[3] == $past(dirBitPortb[3])) else $error("B3 dir wrong");
  a_forced_pullup:    assert property (@(posedge clk) disable iff (!arst_n) spiSlave |=> padPullupPortb[2] == $past(outBitPortb[2] & ~globalPullupDisable)) else $error("B2 pull-up wrong");
  a_ss_active:        assert property (@(posedge clk) disable iff (!arst_n) spiSlaveActive |-> $past(spiSlave) && !$past(syncB2[2])) else $error("slave active while unselected");
  a_timer1_compare_a_out_needs_dir:   assert property (@(posedge clk) disable iff (!arst_n) (timer1CompareAEn && dirBitPortb[1]) |=> padOutPortb[1] == $past(timer1CompareAOut) && padOePortb[1]) else $error("TIMER1_COMPARE_A_OUT not routed");
  a_b3_or_value:      assert property (@(posedge clk) disable iff (!arst_n) (spiMaster && timer2CompareEn) |=> padOutPortb[3] == $past(spiMasterOut | timer2CompareOut)) else $error("B3 OR wrong");
  a_reset_reads_zero: assert property (@(posedge clk) disable iff (!arst_n) !resetPinDisableFuse |=> !padOePortc[6] && !dirReadPortc[6] && !outReadPortc[6] && !inBitPortc[6]) else $error("reset pin not zero");
  a_tw_open_drain:    assert property (@(posedge clk) disable iff (!arst_n) twowireEnable |=> !padOutPortc[5] && !padOutPortc[4] && padOePortc[5] == $past(twowireClkDriveLow)) else $error("two-wire not open-drain");
  a_pud_off:          assert property (@(posedge clk) disable iff (!arst_n) (globalPullupDisable && !spiSlave) |=> padPullupPortb == 4'h0) else $error("pull-up despite disable");

  // ====================================================================
  // SPI pin assertions
  // Each check compares an output with the inputs one edge earlier, since every output is registered.
  sequence s_masterOn;
    spiMaster;
  endsequence
  sequence s_b2FollowsDir;
    padOePortb[2] == $past(dirBitPortb[2]);
  endsequence
  a_master_b2_dir:    assert property (@(posedge clk) disable iff (!arst_n)
    s_masterOn |=> s_b2FollowsDir) else $error("B2 dir wrong");
  a_b3_pullup:        assert property (@(posedge clk) disable iff (!arst_n)
    s_slaveOn |=> padPullupPortb[3] == $past(outBitPortb[3] & ~globalPullupDisable)) else $error("B3 pull-up wrong");
  a_forced_pu_gate:   assert property (@(posedge clk) disable iff (!arst_n)
    (spiSlave && globalPullupDisable) |=> !padPullupPortb[3] && !padPullupPortb[2]) else $error("forced pull-up on");
  a_dir_override:     assert property (@(posedge clk) disable iff (!arst_n)
    (spiSlave && dirBitPortb[2]) |=> !padOePortb[2]) else $error("direction override ignored");
  a_miso_master_in:   assert property (@(posedge clk) disable iff (!arst_n)
    s_masterOn |=> !padOeMiso) else $error("MISO driven in master");
  a_miso_slave_out:   assert property (@(posedge clk) disable iff (!arst_n)
    s_slaveOn |=> padOutMiso == $past(spiSlaveOut)) else $error("MISO value wrong");
  a_mosi_slave_in:    assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> spiSlaveIn == $past(syncB2[3])) else $error("MOSI input wrong");

  // ====================================================================
  // Timer pin assertions
  // The compare overrides steer only the level, so a driver off stays off.
  a_oc2_needs_dir:    assert property (@(posedge clk) disable iff (!arst_n)
    (timer2CompareEn && !dirBitPortb[3]) |=> !padOePortb[3]) else $error("OC2 enabled driver");
  a_oc2_pwm_level:    assert property (@(posedge clk) disable iff (!arst_n)
    (timer2CompareEn && !spiMaster) |=> padOutPortb[3] == $past(timer2CompareOut)) else $error("OC2 level wrong");
  a_timer1_compare_b_out_needs_dir:   assert property (@(posedge clk) disable iff (!arst_n)
    (timer1CompareBEn && dirBitPortb[2] && !spiSlave) |=> padOutPortb[2] == $past(timer1CompareBOut) && padOePortb[2])
    else $error("TIMER1_COMPARE_B_OUT not routed");
  a_value_override:   assert property (@(posedge clk) disable iff (!arst_n)
    timer1CompareAEn |=> padOutPortb[1] == $past(timer1CompareAOut)) else $error("value override ignored");
  a_cap_no_ovr:       assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> padOePortb[0] == $past(dirBitPortb[0]) && padOutPortb[0] == $past(outBitPortb[0])
    && timer1CaptureIn == $past(syncB2[0])) else $error("capture pin overridden");

  // ====================================================================
  // Reset pin assertions
  a_fuse_plain_io:    assert property (@(posedge clk) disable iff (!arst_n)
    resetPinDisableFuse |=> padOePortc[6] == $past(dirBitPortc[6]) && resetPinLevel) else $error("C6 not plain I/O");
  a_fuse_reset_pin:   assert property (@(posedge clk) disable iff (!arst_n)
    !resetPinDisableFuse |=> padPullupPortc[6] && resetPinLevel == $past(syncC2[6])) else $error("C6 not reset");

  // ====================================================================
  // Two-wire assertions
  // A filtered line may only change after its synchronised input held the new level five edges.
  a_tw_clk_detach:    assert property (@(posedge clk) disable iff (!arst_n)
    twowireEnable |=> !inBitPortc[5] && padOePortc[5] == $past(twowireClkDriveLow)) else $error("C5 not detached");
  a_tw_dat_detach:    assert property (@(posedge clk) disable iff (!arst_n)
    twowireEnable |=> !inBitPortc[4] && padOePortc[4] == $past(twowireDatDriveLow)) else $error("C4 not detached");
  a_tw_pu_override:   assert property (@(posedge clk) disable iff (!arst_n)
    twowireEnable |=> !padPullupPortc[5] && !padPullupPortc[4]) else $error("two-wire pull-up on");
  a_clk_spike_gap:    assert property (@(posedge clk) disable iff (!arst_n)
    $changed(filtClk) |-> $past(syncC2[5]) == filtClk && $past(syncC2[5], 5) == filtClk) else $error("clock spike passed");
  a_dat_spike_gap:    assert property (@(posedge clk) disable iff (!arst_n)
    $changed(filtDat) |-> $past(syncC2[4]) == filtDat && $past(syncC2[4], 5) == filtDat) else $error("data spike passed");
endmodule
`default_nettype wire

// ---- verif/pbco_periph_model.sv ----
// Purpose: Stand-in for the SPI, timer and two-wire peripherals behind the pins.
// Assumes: The bench sets every peripheral level through one control word.
// Notes:   Levels hold between updates, as the real peripherals hold their state.
`timescale 1ns/1ps
`default_nettype none
module pbco_periph_model (
  // Bench control
  input  wire logic [9:0] periphCfg,
  // Peripheral levels
  output logic            spiMasterOut,
  output logic            spiSlaveOut,
  output logic            timer2CompareOut,
  output logic            timer2CompareEn,
  output logic            timer1CompareAOut,
  output logic            timer1CompareAEn,
  output logic            timer1CompareBOut,
  output logic            timer1CompareBEn,
  output logic            twowireClkDriveLow,
  output logic            twowireDatDriveLow
);
  // A PWM waveform is just a compare level that the bench toggles.
  assign {twowireDatDriveLow, twowireClkDriveLow, timer1CompareBEn, timer1CompareBOut, timer1CompareAEn,
          timer1CompareAOut, timer2CompareEn, timer2CompareOut, spiSlaveOut, spiMasterOut} = periphCfg;
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the port B/C override block.
// Assumes: Outputs settle one edge after control, three after a pad change, eight through the two-wire spike filters.
// Notes:   Inputs change at the falling edge, outputs are read there too.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk, arst_n, globalPullupDisable, resetPinDisableFuse, spiEnableBit, spiMasterSelect;
  logic       padInMiso, dirBitMiso, twowireEnable, spiSlaveIn, spiMasterIn, spiSlaveSelectIn, spiSlaveActive;
  logic       padOutMiso, padOeMiso, timer1CaptureIn, resetPinLevel, twowireClkIn, twowireDatIn;
  logic       spiMasterOut, spiSlaveOut, timer2CompareOut, timer2CompareEn, timer1CompareAOut;
  logic       timer1CompareAEn, timer1CompareBOut, timer1CompareBEn, twowireClkDriveLow, twowireDatDriveLow;
  logic [3:0] dirBitPortb, outBitPortb, padInPortb, padOutPortb, padOePortb, padPullupPortb, inBitPortb;
  logic [6:0] dirBitPortc, outBitPortc, padInPortc, padOutPortc, padOePortc, padPullupPortc;
  logic [6:0] inBitPortc, dirReadPortc, outReadPortc;
  logic [9:0] periphCfg;
  int         bad_count, tests_run;
  pbco_override pbco_override_i (.*);
  pbco_periph_model pbco_periph_model_i (.*);
  always #5 clk = ~clk;
  task chk(input logic [6:0] seen, input logic [6:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Drops C5 low for w cycles and reports whether the filtered clock ever fell.
  task pulse(input int w, input logic exp);
    logic low;
    low = 1'b0;
    padInPortc[5] = 1'b0;
    repeat (16) begin
      step(1);
      if (--w == 0) padInPortc[5] = 1'b1;
      if (twowireClkIn === 1'b0) low = 1'b1;
    end
    chk(low, exp);
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20us;
    bad_count++;
    close_out();
  end
  initial begin
    {clk, arst_n, globalPullupDisable, resetPinDisableFuse, spiEnableBit, spiMasterSelect} = 6'h00;
    {padInMiso, dirBitMiso, twowireEnable, periphCfg} = 13'h0000;
    {dirBitPortb, outBitPortb, dirBitPortc, outBitPortc} = 22'h000000;
    padInPortb = 4'hF;
    padInPortc = 7'h7F;
    step(8);
    arst_n = 1'b1;
    // Slave role: B3 and B2 forced to input whatever the direction bits say.
    {dirBitPortb, outBitPortb, spiEnableBit, dirBitMiso, periphCfg} = {8'hFC, 2'h3, 10'h002};
    step(1);
    chk(padOePortb[3:2], 7'h00);
    chk(padPullupPortb[3:2], 7'h03);
    chk({padOeMiso, padOutMiso}, 7'h03);
    globalPullupDisable = 1'b1;
    step(1);
    chk(padPullupPortb[3:2], 7'h00);
    for (int i = 0; i < 2; i++) begin
      padInPortb = i ? 4'hC : 4'h3;
      step(4);
      chk({spiSlaveSelectIn, spiSlaveActive, spiSlaveIn}, i ? 7'h05 : 7'h02);
    end
    $display("spi slave test done");
    // Master role: B3/B2 drivers follow direction bits, MISO driver forced off, B3 carries SPI out OR timer 2.
    {spiMasterSelect, dirBitPortb, padInMiso} = {1'b1, 4'h4, 1'b1};
    step(1);
    chk(padOePortb[3:2], 7'h01);
    dirBitPortb = 4'h8;
    for (int i = 0; i < 4; i++) begin
      periphCfg = {6'h00, 1'b1, i[1], 1'b0, i[0]};
      step(1);
      chk({padOePortb[3:2], padOutPortb[3]}, 7'h04 | 7'(i[0] | i[1]));
    end
    step(3);
    chk({spiMasterIn, padOeMiso}, 7'h02);
    $display("spi master test done");
    // Timers alone: compare levels reach the pins only where the pin is an output.
    {spiEnableBit, outBitPortb, dirBitPortb, periphCfg} = {1'b0, 4'h0, 4'h0, 10'h0FC};
    step(1);
    chk(padOePortb[3:1], 7'h00);
    {dirBitPortb, padInPortb} = 8'hF1;
    for (int i = 0; i < 4; i++) begin
      periphCfg[2] = i[0];
      step(1);
      chk({padOePortb[3:1], padOutPortb[3:1]}, {1'b0, 3'h7, i[0], 2'h3});
    end
    step(3);
    chk({timer1CaptureIn, padOePortb[0], padOutPortb[0], padPullupPortb[0]}, 7'h0C);
    $display("timer test done");
    // Reset pin: plain I/O with the fuse programmed, reads zero without it.
    {resetPinDisableFuse, dirBitPortc, outBitPortc} = {1'b1, 7'h40, 7'h40};
    step(4);
    chk({padOePortc[6], padOutPortc[6], inBitPortc[6], dirReadPortc[6]}, 7'h0F);
    resetPinDisableFuse = 1'b0;
    step(4);
    chk({dirReadPortc[6], outReadPortc[6], inBitPortc[6]}, 7'h00);
    chk({padOePortc[6], padOutPortc[6], padPullupPortc[6], resetPinLevel}, 7'h03);
    padInPortc[6] = 1'b0;
    step(4);
    chk(resetPinLevel, 7'h00);
    $display("reset pin test done");
    // Two-wire: port bits ignored, lines open drain, short spikes dropped.
    {globalPullupDisable, dirBitPortc, outBitPortc} = {1'b0, 7'h30, 7'h30};
    {twowireEnable, periphCfg} = {1'b1, 10'h100};
    step(4);
    chk({padOePortc[5:4], padOutPortc[5:4], padPullupPortc[5:4]}, 7'h20);
    chk(inBitPortc[5:4], 7'h00);
    pulse(4, 1'b0);
    pulse(5, 1'b1);
    padInPortc[4] = 1'b0;
    step(10);
    chk(twowireDatIn, 7'h00);
    twowireEnable = 1'b0;
    step(1);
    chk({padOePortc[5], padOutPortc[5]}, 7'h03);
    $display("two-wire test done");
    close_out();
  end
endmodule
`default_nettype wire
